// file: rtl/bitset_shift_pkg.sv
package bitset_shift_pkg;

    // ------------------------------------------------------------
    // Opcode bytes and fields
    // ------------------------------------------------------------
    localparam logic [7:0] PREFIX_BYTE      = 8'h0F;
    localparam logic [7:0] CARRY_SET_BYTE   = 8'hF9;
    localparam logic [7:0] DIR_SET_BYTE     = 8'hFD;
    localparam logic [6:0] SHIFT_ONE_HI     = 7'h68;
    localparam logic [6:0] SHIFT_COUNT_HI   = 7'h69;
    localparam logic [6:0] SHIFT_IMM_HI     = 7'h60;
    localparam logic [2:0] BITSET_HI_FIELD  = 3'h0;
    localparam logic [1:0] BITSET_MID_FIELD = 2'h2;
    localparam logic       BITSET_TWO_BIT   = 1'b0;
    localparam logic [2:0] OP_LEFT          = 3'h4;
    localparam logic [2:0] OP_RIGHT         = 3'h5;
    localparam logic [2:0] BITSET_REG_FIELD = 3'h0;
    localparam logic [1:0] MODE_REGISTER    = 2'h3;
    localparam logic [1:0] MODE_NO_DISP     = 2'h0;
    localparam logic [1:0] MODE_DISP8       = 2'h1;
    localparam logic [1:0] MODE_DISP16      = 2'h2;
    localparam logic [2:0] MEM_DIRECT       = 3'h6;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int WIDTH_BIT_POS  = 0;
    localparam int IMM_BIT_POS    = 3;
    localparam int BYTE_SIGN_POS  = 7;
    localparam int WORD_SIGN_POS  = 15;
    localparam int BYTE_INDEX_W   = 3;
    localparam int WORD_INDEX_W   = 4;

    // ------------------------------------------------------------
    // Lengths and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] LEN_ONE       = 3'h1;
    localparam logic [2:0] LEN_SHIFT_REG = 3'h2;
    localparam logic [2:0] LEN_BITSET    = 3'h3;
    localparam logic [2:0] MAX_LEN       = 3'h6;
    localparam logic       CARRY_RESET   = 1'b0;
    localparam logic       DIR_RESET     = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_COLLECT = 4'b0010,
        ST_EXEC    = 4'b0100,
        ST_DONE    = 4'b1000
    } state_type;

    typedef enum logic [2:0] {
        KIND_NONE  = 3'h0,
        KIND_CSET  = 3'h1,
        KIND_DSET  = 3'h2,
        KIND_BSET  = 3'h3,
        KIND_SHIFT = 3'h4
    } kind_type;

    typedef struct packed {
        logic zero;
        logic sign;
        logic parity;
        logic overflow;
        logic auxCarry;
        logic carry;
    } flags_type;

    typedef struct packed {
        logic [15:0] value;
        flags_type   flags;
        logic        writeBack;
        logic        flagsWrite;
        logic        wordOp;
        logic [2:0]  regNum;
        logic        memOp;
        logic [1:0]  addrMode;
        logic [2:0]  memCode;
        logic [15:0] disp;
    } result_type;

endpackage

// file: rtl/bitset_shift_unit.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Bit-index set writes selected destination bit
// - Count register index masked to 3/4 bits
// - Carry-set form forces carry only
// - Direction-set makes block index steps decrement
// - Carry-set opcode byte F9, one byte
// - Direction-set opcode byte FD, one byte
// - Displacement then immediate index last
// - Bit-set lengths 3, 3-5, 4, 4-6
// - Left by one: zero in, top to carry
// - Left by count: last bit out carried
// - Right by one: zero top, bit0 carried
// - Right by count: last bit0 out carried
// - Single shift overflow equals sign change
// - Single shift updates five flags, aux undefined
// - Count shift updates four flags, overflow undefined
// - Opcode 1101000w shifts by one
// - Opcode 1101001w shifts by count register
// - Opcode 1100000w shifts by trailing byte
// - Operation field 100 selects left shift
// - Operation field 101 selects right shift
// - Shift lengths 2, 2-4, 3, 3-5
module bitset_shift_unit (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        clkEn,
    // Instruction byte stream
    input  wire logic                        byteValid,
    input  wire logic [7:0]                  byteData,
    output logic                             byteReady,
    // Operand and core state
    input  wire logic [15:0]                 operandData,
    input  wire logic [7:0]                  countByte,
    input  wire bitset_shift_pkg::flags_type flagsIn,
    // Results
    output logic                             resultValid,
    output bitset_shift_pkg::result_type     resultOut,
    output logic [2:0]                       instrLength,
    output logic                             illegalOp,
    // Flags held in this block
    output logic                             carryFlag,
    output logic                             blockStepDown
);
    import bitset_shift_pkg::*;

    // ------------------------------------------------------------
    // Decode state
    // ------------------------------------------------------------
    state_type   state_reg;
    kind_type    kind_reg;
    logic [7:0]  bytes_reg [0:5];
    logic [2:0]  count_reg;
    logic [2:0]  need_reg;
    logic [2:0]  need_next;
    logic        addrStep;
    logic [2:0]  needNow;
    logic        carry_reg;
    logic        dir_reg;
    result_type  res_reg;
    logic        valid_reg;
    logic        illegal_reg;
    logic [2:0]  len_reg;

    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [1:0]  modeBits;
    logic [2:0]  memBits;
    logic [2:0]  dispLen;
    logic        isShift;
    logic        isBitSet;
    logic        immIndex;
    logic        wordSel;
    logic [2:0]  opField;
    logic [7:0]  lastByte;
    logic [7:0]  shiftCount;
    logic [3:0]  bitIndex;
    logic [15:0] bitMask;
    logic        leftSel;
    logic [15:0] shiftResult;
    flags_type   shiftFlags;
    logic        shiftNoChange;
    logic        badForm;

    assign b0 = bytes_reg[0];
    assign b1 = bytes_reg[1];
    assign b2 = bytes_reg[2];
    assign byteReady = (state_reg == ST_IDLE) || (state_reg == ST_COLLECT);

    // ------------------------------------------------------------
    // Length of the addressing tail
    // ------------------------------------------------------------
    function automatic logic [2:0] disp_bytes(input logic [1:0] mode, input logic [2:0] mem);
        logic [2:0] n;
        n = 3'h0;
        case (mode)
            MODE_NO_DISP: n = (mem == MEM_DIRECT) ? 3'h2 : 3'h0;
            MODE_DISP8:   n = 3'h1;
            MODE_DISP16:  n = 3'h2;
            default:      n = 3'h0;
        endcase
        return n;
    endfunction

    // ------------------------------------------------------------
    // Expected length once the addressing byte is seen
    // ------------------------------------------------------------
    always_comb begin
        isShift  = (b0[7:1] == SHIFT_ONE_HI) || (b0[7:1] == SHIFT_COUNT_HI) ||
                   (b0[7:1] == SHIFT_IMM_HI);
        isBitSet = (b1[7:5] == BITSET_HI_FIELD) && b1[4] && (b1[2:1] == BITSET_MID_FIELD) &&
                   (b1[1] == BITSET_TWO_BIT);
        immIndex = b1[IMM_BIT_POS];
        modeBits = byteData[7:6];
        memBits  = byteData[2:0];
        addrStep = ((kind_reg == KIND_SHIFT) && (count_reg == 3'h1)) ||
                   ((kind_reg == KIND_BSET) && (count_reg == 3'h2));
        dispLen  = (modeBits == MODE_REGISTER) ? 3'h0 : disp_bytes(modeBits, memBits);
        if (isShift) begin
            need_next = LEN_SHIFT_REG + dispLen + ((b0[7:1] == SHIFT_IMM_HI) ? 3'h1 : 3'h0);
        end else begin
            need_next = LEN_BITSET + dispLen + (immIndex ? 3'h1 : 3'h0);
        end
        needNow = addrStep ? need_next : need_reg;
    end

    // ------------------------------------------------------------
    // Byte collection and sequencing
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            kind_reg  <= KIND_NONE;
            count_reg <= 3'h0;
            need_reg  <= MAX_LEN;
        end else if (clkEn) begin
            case (state_reg)
                ST_IDLE: begin
                    if (byteValid) begin
                        count_reg <= 3'h1;
                        need_reg  <= MAX_LEN;
                        if (byteData == CARRY_SET_BYTE) begin
                            kind_reg  <= KIND_CSET;
                            state_reg <= ST_EXEC;
                        end else if (byteData == DIR_SET_BYTE) begin
                            kind_reg  <= KIND_DSET;
                            state_reg <= ST_EXEC;
                        end else if (byteData == PREFIX_BYTE) begin
                            kind_reg  <= KIND_BSET;
                            state_reg <= ST_COLLECT;
                        end else if ((byteData[7:1] == SHIFT_ONE_HI) || (byteData[7:1] == SHIFT_COUNT_HI) ||
                                     (byteData[7:1] == SHIFT_IMM_HI)) begin
                            kind_reg  <= KIND_SHIFT;
                            state_reg <= ST_COLLECT;
                        end else begin
                            kind_reg  <= KIND_NONE;
                            state_reg <= ST_EXEC;
                        end
                    end
                end
                ST_COLLECT: begin
                    if (byteValid) begin
                        count_reg <= count_reg + 3'h1;
                        if (addrStep) begin
                            need_reg <= need_next;
                        end
                        if ((count_reg + 3'h1) >= needNow) begin
                            state_reg <= ST_EXEC;
                        end
                    end
                    if (count_reg >= need_reg) begin
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: state_reg <= ST_DONE;
                ST_DONE: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Instruction byte storage
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_bytes
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    bytes_reg[gi] <= 8'h00;
                end else if (clkEn && byteValid && byteReady) begin
                    if ((state_reg == ST_IDLE && gi == 0) ||
                        (state_reg == ST_COLLECT && count_reg == 3'(gi))) begin
                        bytes_reg[gi] <= byteData;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Operand preparation
    // ------------------------------------------------------------
    always_comb begin
        lastByte = bytes_reg[count_reg - 3'h1];
        wordSel  = (kind_reg == KIND_SHIFT) ? b0[WIDTH_BIT_POS] : b1[WIDTH_BIT_POS];
        opField  = b1[5:3];
        leftSel  = (opField == OP_LEFT);
        badForm  = (kind_reg == KIND_SHIFT) && (opField != OP_LEFT) && (opField != OP_RIGHT);
        if (b0[7:1] == SHIFT_ONE_HI) begin
            shiftCount = 8'h01;
        end else if (b0[7:1] == SHIFT_COUNT_HI) begin
            shiftCount = countByte;
        end else begin
            shiftCount = lastByte;
        end
        bitIndex = immIndex ? lastByte[3:0] : countByte[3:0];
        if (!wordSel) begin
            bitIndex[BYTE_INDEX_W] = 1'b0;
        end
        bitMask = 16'h0001 << bitIndex;
    end

    shift_core u_shift_core (
        .leftDir  (leftSel),
        .wordOp   (wordSel),
        .count    (shiftCount),
        .operand  (operandData),
        .flagsIn  (flagsIn),
        .result   (shiftResult),
        .flagsOut (shiftFlags),
        .noChange (shiftNoChange)
    );

    // ------------------------------------------------------------
    // Result register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            res_reg     <= '0;
            valid_reg   <= 1'b0;
            illegal_reg <= 1'b0;
            len_reg     <= LEN_ONE;
        end else if (clkEn) begin
            valid_reg   <= 1'b0;
            illegal_reg <= 1'b0;
            if (state_reg == ST_EXEC) begin
                valid_reg          <= 1'b1;
                len_reg            <= count_reg;
                res_reg            <= '0;
                res_reg.flags      <= flagsIn;
                res_reg.wordOp     <= wordSel;
                res_reg.addrMode   <= (kind_reg == KIND_SHIFT) ? b1[7:6] : b2[7:6];
                res_reg.regNum     <= (kind_reg == KIND_SHIFT) ? b1[2:0] : b2[2:0];
                res_reg.memCode    <= (kind_reg == KIND_SHIFT) ? b1[2:0] : b2[2:0];
                res_reg.memOp      <= ((kind_reg == KIND_SHIFT) ? b1[7:6] : b2[7:6]) != MODE_REGISTER;
                res_reg.disp       <= (kind_reg == KIND_SHIFT) ? {bytes_reg[3], b2} : {bytes_reg[4], bytes_reg[3]};
                case (kind_reg)
                    KIND_BSET: begin
                        if (isBitSet && b2[5:3] == BITSET_REG_FIELD) begin
                            res_reg.value     <= operandData | bitMask;
                            res_reg.writeBack <= 1'b1;
                        end else begin
                            illegal_reg <= 1'b1;
                        end
                    end
                    KIND_SHIFT: begin
                        if (badForm) begin
                            illegal_reg <= 1'b1;
                        end else begin
                            res_reg.value      <= shiftResult;
                            res_reg.flags      <= shiftFlags;
                            res_reg.writeBack  <= !shiftNoChange;
                            res_reg.flagsWrite <= !shiftNoChange;
                        end
                    end
                    KIND_CSET: begin
                        res_reg.flags.carry <= 1'b1;
                    end
                    KIND_DSET: begin
                        res_reg.value <= operandData;
                    end
                    default: illegal_reg <= 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Carry and direction flags
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            carry_reg <= CARRY_RESET;
            dir_reg   <= DIR_RESET;
        end else if (clkEn && state_reg == ST_EXEC) begin
            if (kind_reg == KIND_CSET) begin
                carry_reg <= 1'b1;
            end else if (kind_reg == KIND_SHIFT && !badForm && !shiftNoChange) begin
                carry_reg <= shiftFlags.carry;
            end
            if (kind_reg == KIND_DSET) begin
                dir_reg <= 1'b1;
            end
        end
    end

    assign resultValid   = valid_reg;
    assign resultOut     = res_reg;
    assign instrLength   = len_reg;
    assign illegalOp     = illegal_reg;
    assign carryFlag     = carry_reg;
    assign blockStepDown = dir_reg;

endmodule
`default_nettype wire

// file: rtl/shift_core.sv
`timescale 1ns/100ps
`default_nettype none
module shift_core (
    // Operation select
    input  wire logic                      leftDir,
    input  wire logic                      wordOp,
    input  wire logic [7:0]                count,
    // Operand
    input  wire logic [15:0]               operand,
    input  wire bitset_shift_pkg::flags_type flagsIn,
    // Result
    output logic [15:0]                    result,
    output bitset_shift_pkg::flags_type    flagsOut,
    output logic                           noChange
);
    import bitset_shift_pkg::*;

    logic [16:0] wide;
    logic [16:0] shifted;
    logic        signBit;
    logic        oldSign;

    always_comb begin
        wide     = 17'h00000;
        shifted  = 17'h00000;
        result   = operand;
        flagsOut = flagsIn;
        noChange = (count == 8'h00);
        if (leftDir) begin
            wide    = {1'b0, (wordOp ? operand : {8'h00, operand[7:0]})};
            shifted = (count > 8'h10) ? 17'h00000 : (wide << count);
            result  = shifted[15:0];
            if (wordOp) begin
                flagsOut.carry = (count > 8'h10) ? 1'b0 : shifted[16];
            end else begin
                flagsOut.carry = (count > 8'h08) ? 1'b0 : shifted[8];
                result  = {8'h00, shifted[7:0]};
            end
        end else begin
            wide    = {(wordOp ? operand : {8'h00, operand[7:0]}), 1'b0};
            shifted = (count > 8'h10) ? 17'h00000 : (wide >> count);
            result  = shifted[16:1];
            flagsOut.carry = shifted[0];
        end
        signBit = wordOp ? result[WORD_SIGN_POS] : result[BYTE_SIGN_POS];
        oldSign = wordOp ? operand[WORD_SIGN_POS] : operand[BYTE_SIGN_POS];
        flagsOut.sign     = signBit;
        flagsOut.zero     = wordOp ? (result == 16'h0000) : (result[7:0] == 8'h00);
        flagsOut.parity   = ~^result[7:0];
        flagsOut.auxCarry = 1'b0;
        flagsOut.overflow = (count == 8'h01) ? (signBit ^ oldSign) : 1'b0;
        if (!wordOp) begin
            result[15:8] = operand[15:8];
        end
        if (noChange) begin
            result   = operand;
            flagsOut = flagsIn;
        end
    end

endmodule
`default_nettype wire

// file: sim/bitset_shift_checker.sv
`timescale 1ns/100ps
`default_nettype none
module bitset_shift_checker (
    // Clock and reset
    input wire logic                         ref_clk,
    input wire logic                         rst_n,
    input wire logic                         clkEn,
    // Stream and results
    input wire logic [7:0]                   byteData,
    input wire logic                         byteReady,
    input wire logic                         resultValid,
    input wire bitset_shift_pkg::result_type resultOut,
    input wire logic [2:0]                   instrLength,
    input wire logic                         illegalOp,
    // Held flags
    input wire logic                         carryFlag,
    input wire logic                         blockStepDown
);
    import bitset_shift_pkg::*;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_refuse;
        !byteReady ##1 byteReady;
    endsequence
    sequence s_quiet;
        !resultValid [*2];
    endsequence

    a_refuse_window: assert property (resultValid && clkEn |-> !$past(byteReady) ##0 s_refuse)
        else $error("stream not refused around a result");
    a_pulse_gap: assert property (resultValid && clkEn |=> s_quiet)
        else $error("results closer than one instruction");
    a_carry_opcode: assert property (resultValid && instrLength == LEN_ONE &&
        $past(byteData, 2) == CARRY_SET_BYTE |-> carryFlag && $stable(blockStepDown))
        else $error("carry set form did not set carry alone");
    a_dir_opcode: assert property (resultValid && instrLength == LEN_ONE &&
        $past(byteData, 2) == DIR_SET_BYTE |-> blockStepDown && $stable(carryFlag))
        else $error("direction set form did not set direction alone");
    a_carry_moves: assert property ($past(rst_n) && $changed(carryFlag) |-> resultValid)
        else $error("carry changed without a result");
    a_dir_only_set: assert property ($past(rst_n) && $changed(blockStepDown) |->
        blockStepDown && resultValid)
        else $error("direction flag changed other than by a set");
    a_illegal_pulse: assert property (illegalOp |-> resultValid)
        else $error("illegal flag without a result");
    a_result_hold: assert property ($past(rst_n) && !resultValid |->
        $stable(instrLength) && $stable(resultOut))
        else $error("result moved between results");
endmodule
bind bitset_shift_unit bitset_shift_checker bitset_shift_checker_inst (
    .ref_clk, .rst_n, .clkEn, .byteData, .byteReady, .resultValid,
    .resultOut, .instrLength, .illegalOp, .carryFlag, .blockStepDown
);
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import bitset_shift_pkg::*;

    logic        ref_clk;
    logic        rst_n;
    logic        byteValid;
    logic [7:0]  byteData;
    logic        byteReady;
    logic [15:0] operandData;
    logic [7:0]  countByte;
    flags_type   flagsIn;
    logic        resultValid;
    result_type  resultOut;
    logic [2:0]  instrLength;
    logic        illegalOp;
    logic        carryFlag;
    logic        blockStepDown;
    int          errorCnt;
    int          compares;
    result_type  res;

    bitset_shift_unit bitset_shift_unit_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(1'b1), .byteValid(byteValid),
        .byteData(byteData), .byteReady(byteReady), .operandData(operandData),
        .countByte(countByte), .flagsIn(flagsIn), .resultValid(resultValid),
        .resultOut(resultOut), .instrLength(instrLength), .illegalOp(illegalOp),
        .carryFlag(carryFlag), .blockStepDown(blockStepDown)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results;
        $display("errors %0d compares %0d", errorCnt, compares);
        if (errorCnt == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chkf(input string name, input flags_type exp, input flags_type got);
        chk(name, {10'h000, exp}, {10'h000, got});
    endtask

    task automatic waitfor(input logic sig, inout int n);
        if (n >= 20) begin
            errorCnt++;
            $display("[ERR] wait expected done seen timeout");
            results();
        end
    endtask

    task automatic run(input logic [7:0] q[$]);
        int n;
        foreach (q[i]) begin
            n = 0;
            while (byteReady !== 1'b1 && n < 20) begin
                @(negedge ref_clk);
                n++;
            end
            waitfor(byteReady, n);
            byteValid = 1'b1;
            byteData = q[i];
            @(negedge ref_clk);
        end
        byteValid = 1'b0;
        n = 0;
        while (resultValid !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        waitfor(resultValid, n);
        chk("latency", 16'h0001, 16'(n));
        res = resultOut;
    endtask

    task automatic shift(input logic [7:0] q[$], input logic left, input logic word, input logic one,
                         input logic [15:0] op, input logic [7:0] cnt, input logic [2:0] ln);
        logic [16:0] v;
        flags_type   f;
        logic        c;
        int          w;
        w = word ? 16 : 8;
        v = word ? {1'b0, op} : {9'h000, op[7:0]};
        c = 1'b0;
        for (int i = 0; i < cnt; i++) begin
            c = left ? v[w - 1] : v[0];
            v = left ? v << 1 : v >> 1;
            v = v & (word ? 17'h0FFFF : 17'h000FF);
        end
        f = {v[15:0] == 16'h0000, v[w - 1], ~^v[7:0], one & (v[w - 1] ^ op[w - 1]), 1'b0, c};
        operandData = op;
        run(q);
        chk("shift value", v[15:0], word ? res.value : {8'h00, res.value[7:0]});
        chkf("shift flags", f, res.flags);
        chk("shift length", {13'h0000, ln}, {13'h0000, instrLength});
        chk("shift write", 16'h0003, {14'h0000, res.writeBack, res.wordOp ^ ~word});
    endtask

    task automatic bset(input logic [7:0] q[$], input logic word, input logic [15:0] op,
                        input logic [7:0] idx, input logic [2:0] ln);
        logic [15:0] e;
        e = word ? op | (16'h0001 << idx[3:0]) : {8'h00, op[7:0] | (8'h01 << idx[2:0])};
        operandData = op;
        run(q);
        chk("bit set value", e, word ? res.value : {8'h00, res.value[7:0]});
        chk("bit set length", {13'h0000, ln}, {13'h0000, instrLength});
        chk("bit set write", 16'h0001, {15'h0000, res.writeBack});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_flag_sets;
        run('{CARRY_SET_BYTE});
        chk("carry", 16'h0001, {15'h0000, carryFlag});
        chk("direction kept", 16'h0000, {15'h0000, blockStepDown});
        chk("carry length", 16'h0001, {13'h0000, instrLength});
        run('{DIR_SET_BYTE});
        chk("direction", 16'h0001, {15'h0000, blockStepDown});
        chk("carry kept", 16'h0001, {15'h0000, carryFlag});
        chk("direction length", 16'h0001, {13'h0000, instrLength});
    endtask

    task automatic t_single;
        countByte = 8'h07;
        shift('{8'hD0, 8'hE0}, 1'b1, 1'b0, 1'b1, 16'h00C1, 8'h01, 3'h2);
        shift('{8'hD1, 8'hE8}, 1'b0, 1'b1, 1'b1, 16'hC001, 8'h01, 3'h2);
        shift('{8'hD0, 8'h60, 8'h05}, 1'b1, 1'b0, 1'b1, 16'h0040, 8'h01, 3'h3);
    endtask

    task automatic t_count;
        countByte = 8'h03;
        shift('{8'hD2, 8'hE0}, 1'b1, 1'b0, 1'b0, 16'h0035, 8'h03, 3'h2);
        countByte = 8'h14;
        shift('{8'hD3, 8'hE8}, 1'b0, 1'b1, 1'b0, 16'hBEEF, 8'h14, 3'h2);
        countByte = 8'h04;
        shift('{8'hD3, 8'h26, 8'h12, 8'h34}, 1'b1, 1'b1, 1'b0, 16'h0303, 8'h04, 3'h4);
        chk("shift disp", 16'h3412, res.disp);
    endtask

    task automatic t_imm;
        countByte = 8'h01;
        shift('{8'hC0, 8'hE8, 8'h04}, 1'b0, 1'b0, 1'b0, 16'h00F8, 8'h04, 3'h3);
        shift('{8'hC1, 8'h26, 8'h12, 8'h34, 8'h08}, 1'b1, 1'b1, 1'b0, 16'h0103, 8'h08, 3'h5);
        chk("imm disp", 16'h3412, res.disp);
    endtask

    task automatic t_zero;
        countByte = 8'h00;
        operandData = 16'h0055;
        run('{8'hD2, 8'hE0});
        chk("zero count", 16'h0000, {14'h0000, res.writeBack, res.flagsWrite});
    endtask

    task automatic t_bitset;
        countByte = 8'hFB;
        bset('{PREFIX_BYTE, 8'h14, 8'hC3}, 1'b0, 16'h0001, 8'hFB, 3'h3);
        chk("bit set reg", 16'h0003, {13'h0000, res.regNum});
        countByte = 8'hF9;
        bset('{PREFIX_BYTE, 8'h15, 8'hC0}, 1'b1, 16'h0000, 8'hF9, 3'h3);
        bset('{PREFIX_BYTE, 8'h1D, 8'hC1, 8'h1F}, 1'b1, 16'h0000, 8'h1F, 3'h4);
        bset('{PREFIX_BYTE, 8'h1C, 8'h06, 8'h78, 8'h56, 8'h0A}, 1'b0, 16'h0000, 8'h0A, 3'h6);
        chk("bit set disp", 16'h5678, res.disp);
    endtask

    task automatic t_reset;
        run('{8'h90});
        chk("illegal", 16'h0001, {15'h0000, illegalOp});
        @(negedge ref_clk);
        rst_n = 1'b0;
        @(negedge ref_clk);
        rst_n = 1'b1;
        chk("carry reset", {15'h0000, CARRY_RESET}, {15'h0000, carryFlag});
        chk("direction reset", {15'h0000, DIR_RESET}, {15'h0000, blockStepDown});
        chk("length reset", 16'h0001, {13'h0000, instrLength});
    endtask

    initial begin
        rst_n = 1'b0;
        byteValid = 1'b0;
        byteData = 8'h00;
        operandData = 16'h0000;
        countByte = 8'h00;
        flagsIn = 6'h2A;
        errorCnt = 0;
        compares = 0;
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        t_flag_sets();
        t_single();
        t_count();
        t_imm();
        t_zero();
        t_bitset();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
